// ---- hw/trace_word_packer_output.sv ----
`timescale 1ns/1ps
// How it works
// [R1] 64-bit word, type low, formats packed back-to-back
// [R2] type 1 at bit 0, else (type-1)*4, 15
// [R3] type 0 idle words never reach memory
// [R4] probe gathers 64 bits from first nonzero slice
// [R5] sign-bit trimming optional, not done here
// [R6] cycle-inaccurate drops stall-cycle formats
// [R7] cycle-inaccurate strips bit zero of formats
// [R8] cycle-inaccurate drops control codes 0001, 0101
// [R9] mode follows cycle accurate select bit
// [R10] stop code 0100 clears enable, flushes word
// [R11] other enable clear zero-fills and flushes word
// [R12] nine zero bits mark end of trace
// [R13] under nine left: truncated, no further words
// [R14] memory 64 wide, consecutive addresses
// [R15] memory written only on complete words
// [R16] pin bus width 4, 8 or 16
// [R17] whole word shown on word bus
// [R18] slices least significant first, 16/8/4 transfers
// [R19] pin-side multiplier may speed slice transfers
// [R20] idle word bus and pins hold zeros
// [R21] reset clears partial word, type 1 next
module trace_word_packer_output #(
	parameter int ADDR_BITS = 10
) (
	input  wire logic                   SYS_CLK_I,
	input  wire logic                   RST_N_I,
	input  wire logic                   FMT_VALID_I,
	input  wire trace_pack_pkg::fmt_t   FMT_I,
	output logic                        FMT_READY_O,
	input  wire logic                   TRACE_EN_I,
	input  wire logic                   CYCLE_ACC_SEL_I,
	input  wire logic                   ONCHIP_EN_I,
	input  wire logic                   PROBE_EN_I,
	input  wire logic [1:0]             PIN_WIDTH_I,
	output logic                        TRACE_EN_CLR_O,
	output logic                        MEM_WE_O,
	output logic [ADDR_BITS-1:0]        MEM_ADDR_O,
	output logic [63:0]                 MEM_DATA_O,
	output logic [63:0]                 WORD_BUS_O,
	output logic [15:0]                 PINS_O
);
	// ******************************************************************
	// helpers
	// ******************************************************************
	function automatic logic [3:0] type_for(input logic [6:0] rem);
		if (rem == 7'h00)
			type_for = trace_pack_pkg::TYPE_FIRST;
		else if (rem > 7'(trace_pack_pkg::MAX_START))
			type_for = trace_pack_pkg::TYPE_NONE;
		else
			type_for = 4'((rem + 7'h03) >> 2) + 4'h1;
	endfunction

	function automatic logic [6:0] start_of(input logic [3:0] t,
		input logic [6:0] rem);
		if (t == trace_pack_pkg::TYPE_NONE)
			start_of = rem;
		else
			start_of = 7'({3'h0, t - 4'h1} << 2);
	endfunction

	function automatic logic [4:0] pin_bits(input logic [1:0] w);
		case (w)
			trace_pack_pkg::PINW_4:  pin_bits = 5'h04;
			trace_pack_pkg::PINW_8:  pin_bits = 5'h08;
			default:                 pin_bits = 5'h10;
		endcase
	endfunction

	// ******************************************************************
	// format filtering
	// ******************************************************************
	logic               mode_acc;
	logic               drop;
	logic               is_stop;
	logic [63:0]        fdata;
	logic [6:0]         flen;

	always_comb begin
		mode_acc = CYCLE_ACC_SEL_I; // R9
		is_stop = FMT_I.kind == trace_pack_pkg::FMT_CONTROL
			&& FMT_I.code == trace_pack_pkg::CODE_STOP;
		drop = 1'b0;
		if (!mode_acc) begin
			if (FMT_I.kind == trace_pack_pkg::FMT_STALL)
				drop = 1'b1; // R6
			if (FMT_I.kind == trace_pack_pkg::FMT_CONTROL
				&& (FMT_I.code == trace_pack_pkg::CODE_DROP_A
				|| FMT_I.code == trace_pack_pkg::CODE_DROP_B))
				drop = 1'b1; // R8
		end
		fdata = FMT_I.data & ~(64'hFFFF_FFFF_FFFF_FFFF << FMT_I.len);
		flen = FMT_I.len;
		if (!mode_acc && flen != 7'h00) begin
			fdata = fdata >> 1; // R7
			flen = flen - 7'h01;
		end
	end

	// ******************************************************************
	// packer
	// ******************************************************************
	logic [59:0]        acc;
	logic [6:0]         fill;
	logic [3:0]         wtype;
	logic               used;
	logic               stopped;
	logic               en_q;
	logic               flush_pend;
	logic               buf_full;
	logic               take;
	logic               push;
	logic [63:0]        push_word;
	logic [127:0]       comb;
	logic [7:0]         sum;
	logic [6:0]         rem;
	logic [3:0]         ntype;
	logic               do_flush;
	logic [59:0]        next_acc;
	logic [6:0]         next_fill;
	logic [3:0]         next_wtype;
	logic               next_used;
	logic               next_pend;

	// formats are taken only while the buffer can absorb a word
	assign take = FMT_VALID_I && FMT_READY_O && TRACE_EN_I && !stopped
		&& !flush_pend && !drop;

	always_comb begin
		comb = {68'h0, acc} | ({64'h0, fdata} << fill); // R1
		sum = {1'b0, fill} + {1'b0, flen};
		rem = 7'(sum - 8'(trace_pack_pkg::PAYLOAD_BITS));
		ntype = type_for(rem); // R2
		do_flush = flush_pend && !buf_full;
		push = 1'b0;
		push_word = {comb[59:0], wtype};
		next_acc = acc;
		next_fill = fill;
		next_wtype = wtype;
		next_used = used;
		next_pend = flush_pend;
		// R5 sign-bit trimming is left out; decoders accept either form
		if (take) begin
			next_used = 1'b1;
			if (sum >= 8'(trace_pack_pkg::PAYLOAD_BITS)) begin
				push = 1'b1;
				next_acc = comb[119:60];
				next_wtype = ntype;
				next_fill = start_of(ntype, rem);
				next_used = rem != 7'h00;
				next_pend = is_stop && rem != 7'h00; // R10
			end else if (is_stop) begin
				push = 1'b1; // R10
				next_acc = '0;
				next_fill = '0;
				next_wtype = trace_pack_pkg::TYPE_FIRST;
				next_used = 1'b0;
			end else begin
				next_acc = comb[59:0];
				next_fill = sum[6:0];
			end
		end else if (do_flush) begin
			// unused bits of acc are already zero: nine or more zeros
			// read as the end marker, fewer leave a cut format
			push = used; // R11 R12 R13
			push_word = {acc, wtype};
			next_acc = '0;
			next_fill = '0;
			next_wtype = trace_pack_pkg::TYPE_FIRST;
			next_used = 1'b0;
			next_pend = 1'b0;
		end
		if (en_q && !TRACE_EN_I && !stopped && used)
			next_pend = 1'b1; // R11
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			acc <= '0; // R21
			fill <= '0;
			wtype <= trace_pack_pkg::TYPE_FIRST;
			used <= 1'b0;
			flush_pend <= 1'b0;
		end else begin
			acc <= next_acc;
			fill <= next_fill;
			wtype <= next_wtype;
			used <= next_used;
			flush_pend <= next_pend;
		end
	end

	// stop trigger: pulse the enable clear and ignore formats until
	// software lets enable fall
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			en_q <= 1'b0;
			stopped <= 1'b0;
			TRACE_EN_CLR_O <= 1'b0;
		end else begin
			en_q <= TRACE_EN_I;
			TRACE_EN_CLR_O <= take && is_stop; // R10
			if (take && is_stop)
				stopped <= 1'b1;
			else if (!TRACE_EN_I)
				stopped <= 1'b0;
		end
	end

	// ******************************************************************
	// two-entry word buffer
	// ******************************************************************
	logic [63:0]        bmem [trace_pack_pkg::BUF_DEPTH];
	logic               wptr;
	logic               rptr;
	logic [1:0]         cnt;
	logic               pop;
	logic               drain_rdy;
	logic [1:0]         next_cnt;

	assign buf_full = cnt == 2'(trace_pack_pkg::BUF_DEPTH);
	assign pop = cnt != 2'h0 && drain_rdy;
	assign next_cnt = cnt + 2'(push) - 2'(pop);

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			wptr <= 1'b0;
			rptr <= 1'b0;
			cnt <= '0;
			FMT_READY_O <= 1'b0;
		end else begin
			if (push)
				wptr <= ~wptr;
			if (pop)
				rptr <= ~rptr;
			cnt <= next_cnt;
			// a stall at the probe side reaches the format source here
			FMT_READY_O <= next_cnt < 2'(trace_pack_pkg::BUF_DEPTH);
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (push)
			bmem[wptr] <= push_word;
	end

	// ******************************************************************
	// on-chip memory write
	// ******************************************************************
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			MEM_WE_O <= 1'b0;
			MEM_ADDR_O <= '0;
			MEM_DATA_O <= '0;
		end else begin
			MEM_WE_O <= 1'b0;
			if (MEM_WE_O)
				MEM_ADDR_O <= MEM_ADDR_O + ADDR_BITS'(1); // R14
			// every popped word leaves the buffer; only typed words are written to memory
			if (pop && ONCHIP_EN_I
				&& bmem[rptr][3:0] != trace_pack_pkg::TYPE_IDLE) begin
				MEM_WE_O <= 1'b1; // R3 R15
				MEM_DATA_O <= bmem[rptr];
			end
		end
	end

	// ******************************************************************
	// probe serialiser
	// ******************************************************************
	trace_pack_pkg::ser_state_t state;
	logic [63:0]        sh;
	logic [4:0]         left;
	logic [4:0]         wbits;
	logic [4:0]         nslices;

	assign wbits = pin_bits(PIN_WIDTH_I); // R16
	assign nslices = 5'(7'd64 / {2'h0, wbits}); // R18
	assign drain_rdy = !PROBE_EN_I || state == trace_pack_pkg::SER_IDLE;

	// without a fast pin clock one slice leaves per core cycle; a
	// multiplier outside takes the full word from the word bus instead
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			state <= trace_pack_pkg::SER_IDLE;
			sh <= '0;
			left <= '0;
			WORD_BUS_O <= '0;
			PINS_O <= '0;
		end else begin
			case (state)
				trace_pack_pkg::SER_IDLE: begin
					PINS_O <= '0; // R20
					WORD_BUS_O <= '0;
					if (pop && PROBE_EN_I) begin
						WORD_BUS_O <= bmem[rptr]; // R17 R19
						sh <= bmem[rptr];
						left <= nslices;
						state <= trace_pack_pkg::SER_SEND;
					end
				end
				trace_pack_pkg::SER_SEND: begin
					PINS_O <= sh[15:0]
						& ~(16'hFFFF << wbits); // R18
					sh <= sh >> wbits;
					left <= left - 5'h01;
					if (left == 5'h01) begin
						WORD_BUS_O <= '0;
						state <= trace_pack_pkg::SER_IDLE;
					end
				end
				default: state <= trace_pack_pkg::SER_IDLE;
			endcase
		end
	end

	// ******************************************************************
	// checks
	// ******************************************************************
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);

	mem_no_idle_a: assert property (MEM_WE_O |->
		MEM_DATA_O[3:0] != trace_pack_pkg::TYPE_IDLE) // R3
		else $error("idle word written to memory");
	mem_addr_step_a: assert property (MEM_WE_O |=>
		MEM_ADDR_O == $past(MEM_ADDR_O) + ADDR_BITS'(1)) // R14
		else $error("memory address not consecutive");
	type_range_a: assert property (push |->
		push_word[3:0] != trace_pack_pkg::TYPE_IDLE) // R2
		else $error("packed word without type");
	stop_clear_a: assert property (take && is_stop |=>
		TRACE_EN_CLR_O ##1 !TRACE_EN_CLR_O) // R10
		else $error("stop did not pulse enable clear");
	ci_drop_a: assert property (!mode_acc && FMT_VALID_I
		&& FMT_I.kind == trace_pack_pkg::FMT_STALL |-> !take) // R6
		else $error("stall format packed in inaccurate mode");
	idle_zero_a: assert property (state == trace_pack_pkg::SER_IDLE
		&& !(pop && PROBE_EN_I) |=> WORD_BUS_O == '0) // R20
		else $error("word bus not zero while idle");
	slice_first_a: assert property ($rose(state
		== trace_pack_pkg::SER_SEND) && PIN_WIDTH_I == $past(PIN_WIDTH_I)
		|=> PINS_O == (WORD_BUS_O[15:0]
		& ~(16'hFFFF << wbits))) // R18
		else $error("first slice not least significant");
	send_len8_a: assert property ($rose(state
		== trace_pack_pkg::SER_SEND) && PIN_WIDTH_I == trace_pack_pkg::PINW_8
		&& $stable(PIN_WIDTH_I)
		|-> (state == trace_pack_pkg::SER_SEND) [*8]
		##1 state == trace_pack_pkg::SER_IDLE) // R16 R18
		else $error("eight-bit pins did not take eight slices");
	full_stall_a: assert property (buf_full |-> !take) // R15
		else $error("format taken while buffer full");

	stop_seen_c: cover property (take && is_stop);
	spill_seen_c: cover property (take && push && rem != 7'h00);
	flush_seen_c: cover property (do_flush && used);
	full_seen_c: cover property (buf_full && PROBE_EN_I);
endmodule

// ---- hw/trace_pack_pkg.sv ----
package trace_pack_pkg;
	// ******************************************************************
	// trace word layout
	// ******************************************************************
	localparam int          WORD_BITS     = 64;
	localparam int          TYPE_BITS     = 4;
	localparam int          PAYLOAD_BITS  = 60;
	localparam int          TYPE_LSB      = 0;
	localparam int          PAYLOAD_LSB   = 4;
	localparam logic [3:0]  TYPE_IDLE     = 4'h0;
	localparam logic [3:0]  TYPE_FIRST    = 4'h1;
	localparam logic [3:0]  TYPE_NONE     = 4'hF;
	localparam int          MAX_START     = 54;
	localparam int          START_STEP    = 4;
	localparam int          END_MARK_BITS = 9;
	localparam int          LEN_BITS      = 7;
	localparam int          FILL_BITS     = 7;
	// ******************************************************************
	// control format codes
	// ******************************************************************
	localparam logic [3:0]  CODE_STOP     = 4'h4;
	localparam logic [3:0]  CODE_DROP_A   = 4'h1;
	localparam logic [3:0]  CODE_DROP_B   = 4'h5;
	// ******************************************************************
	// probe pin width selection
	// ******************************************************************
	localparam int          PIN_BITS      = 16;
	localparam logic [1:0]  PINW_4        = 2'h0;
	localparam logic [1:0]  PINW_8        = 2'h1;
	localparam logic [1:0]  PINW_16       = 2'h2;
	localparam int          BUF_DEPTH     = 2;
	localparam int          CLK_MHZ       = 100;

	typedef enum logic [1:0] {
		FMT_STALL   = 2'h0,
		FMT_CONTROL = 2'h1,
		FMT_ADDRESS = 2'h2,
		FMT_OTHER   = 2'h3
	} fmt_kind_t;

	typedef struct packed {
		logic [WORD_BITS-1:0] data;
		logic [LEN_BITS-1:0] len;
		fmt_kind_t           kind;
		logic [3:0]          code;
	} fmt_t;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_SEND = 2'b01
	} ser_state_t;
endpackage

// ---- tb/trace_far_side_model.sv ----
`timescale 1ns/1ps
// ******************************************************************
// probe capture and on-chip memory model
// ******************************************************************
module trace_far_side_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [15:0] pins_i,
	input  wire logic [1:0]  width_i,
	input  wire logic        mem_we_i,
	input  wire logic [9:0]  mem_addr_i,
	input  wire logic [63:0] mem_data_i,
	input  wire logic [63:0] word_bus_i,
	output int               probe_cnt_o,
	output int               mem_cnt_o,
	output logic             mem_err_o
);
	logic [63:0] words [0:15];
	logic [63:0] mem   [0:15];
	logic [63:0] bus   [0:15];
	logic [63:0] acc;
	logic [15:0] slice;
	logic        busy;
	int          n;
	int          w;
	always_comb begin
		w = (width_i == trace_pack_pkg::PINW_4) ? 4 :
		    (width_i == trace_pack_pkg::PINW_8) ? 8 : 16;
		slice = pins_i & 16'((32'h1 << w) - 1);
	end
	// gathering restarts only on a nonzero slice, so idle zeros are skipped
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy <= 1'b0;
			n <= 0;
			acc <= '0;
			probe_cnt_o <= 0;
		end else if (busy || slice != 16'h0) begin
			if (n + w >= 64) begin
				words[probe_cnt_o[3:0]] <= acc | (64'(slice) << n);
				probe_cnt_o <= probe_cnt_o + 1;
				busy <= 1'b0;
				n <= 0;
				acc <= '0;
			end else begin
				acc <= acc | (64'(slice) << n);
				n <= n + w;
				busy <= 1'b1;
			end
		end
	end
	// stored by count so that a skipped or repeated address shows up
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mem_cnt_o <= 0;
			mem_err_o <= 1'b0;
		end else if (mem_we_i) begin
			mem[mem_cnt_o[3:0]] <= mem_data_i;
			bus[mem_cnt_o[3:0]] <= word_bus_i;
			mem_cnt_o <= mem_cnt_o + 1;
			if (mem_addr_i != 10'(mem_cnt_o) || mem_data_i[3:0] == 4'h0)
				mem_err_o <= 1'b1;
		end
	end
endmodule

// ---- tb/test_trace_word_packer_output.sv ----
`timescale 1ns/1ps
// ******************************************************************
// packer and output bench
// ******************************************************************
module test_trace_word_packer_output;
	logic                  clk;
	logic                  rst_n;
	logic                  fmt_valid;
	trace_pack_pkg::fmt_t  fmt;
	logic                  fmt_ready;
	logic                  trace_en;
	logic                  cyc_acc;
	logic                  onchip_en;
	logic                  probe_en;
	logic [1:0]            pin_width;
	logic                  en_clr;
	logic                  mem_we;
	logic [9:0]            mem_addr;
	logic [63:0]           mem_data;
	logic [63:0]           word_bus;
	logic [15:0]           pins;
	int                    probe_cnt;
	int                    mem_cnt;
	logic                  mem_err;
	int                    fails;
	int                    checks;
	int                    nw;
	logic                  saw_stall;
	logic                  saw_clr;
	trace_word_packer_output #(.ADDR_BITS(10)) DUT (
		.SYS_CLK_I(clk), .RST_N_I(rst_n), .FMT_VALID_I(fmt_valid),
		.FMT_I(fmt), .FMT_READY_O(fmt_ready), .TRACE_EN_I(trace_en),
		.CYCLE_ACC_SEL_I(cyc_acc), .ONCHIP_EN_I(onchip_en),
		.PROBE_EN_I(probe_en), .PIN_WIDTH_I(pin_width),
		.TRACE_EN_CLR_O(en_clr), .MEM_WE_O(mem_we), .MEM_ADDR_O(mem_addr),
		.MEM_DATA_O(mem_data), .WORD_BUS_O(word_bus), .PINS_O(pins));
	trace_far_side_model PARTNER (
		.clk_i(clk), .rst_n_i(rst_n), .pins_i(pins), .width_i(pin_width),
		.mem_we_i(mem_we), .mem_addr_i(mem_addr), .mem_data_i(mem_data),
		.word_bus_i(word_bus), .probe_cnt_o(probe_cnt),
		.mem_cnt_o(mem_cnt), .mem_err_o(mem_err));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (en_clr === 1'b1) saw_clr = 1'b1;
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// valid stays high on return so back-to-back calls never pulse it
	task automatic send(input trace_pack_pkg::fmt_kind_t k,
		input logic [3:0] c, input logic [6:0] l, input logic [63:0] d);
		int i;
		fmt = '{data: d, len: l, kind: k, code: c};
		fmt_valid = 1'b1;
		for (i = 0; i < 400 && fmt_ready !== 1'b1; i++) begin
			saw_stall = 1'b1;
			@(posedge clk) #1;
		end
		@(posedge clk) #1;
	endtask
	task automatic idle(input int n);
		fmt_valid = 1'b0;
		repeat (n) @(posedge clk) #1;
	endtask
	task automatic expect_word(input logic [63:0] exp);
		int i;
		for (i = 0; i < 400 && probe_cnt <= nw; i++) @(posedge clk) #1;
		chk(PARTNER.words[nw], exp);
		chk(PARTNER.mem[nw], exp);
		chk(PARTNER.bus[nw], exp);
		nw++;
	endtask
	task automatic test_reset;
		chk(word_bus, '0);
		chk(64'({pins, mem_addr, mem_we}), '0);
		chk(64'(fmt_ready), 64'h1);
		// leave a partial word behind and reset in mid-run; the first
		// packed word afterwards shows whether it was cleared
		send(trace_pack_pkg::FMT_OTHER, 4'h0, 7'h0C, 64'hFFF);
		idle(1);
		rst_n = 1'b0;
		repeat (2) @(posedge clk) #1;
		rst_n = 1'b1;
		idle(2);
		chk(64'(fmt_ready), 64'h1);
		chk(64'({pins, mem_addr, mem_we}), '0);
		$display("test reset done");
	endtask
	task automatic test_pack(input logic [1:0] wc);
		pin_width = wc;
		repeat (5) send(trace_pack_pkg::FMT_OTHER, 4'h0, 7'h0C, 64'h5A3);
		idle(2);
		expect_word({{5{12'h5A3}}, 4'h1});
		idle(3);
		chk(word_bus, '0);
		chk(64'(pins), '0);
		$display("test pack width %0d done", wc);
	endtask
	task automatic test_spill_stop;
		pin_width = trace_pack_pkg::PINW_8;
		saw_clr = 1'b0;
		repeat (4) send(trace_pack_pkg::FMT_ADDRESS, 4'h0, 7'h10, 64'hC3C3);
		send(trace_pack_pkg::FMT_CONTROL, trace_pack_pkg::CODE_STOP,
			7'h08, 64'h96);
		idle(3);
		chk(64'(saw_clr), 64'h1);
		trace_en = 1'b0;
		expect_word({60'h3C3C3C3C3C3C3C3, 4'h1});
		expect_word({48'h0, 8'h96, 4'hC, 4'h2});
		idle(3);
		trace_en = 1'b1;
		$display("test spill stop done");
	endtask
	task automatic test_inaccurate;
		pin_width = trace_pack_pkg::PINW_16;
		cyc_acc = 1'b0;
		idle(1);
		send(trace_pack_pkg::FMT_STALL, 4'h0, 7'h01, 64'h1);
		send(trace_pack_pkg::FMT_CONTROL, trace_pack_pkg::CODE_DROP_A,
			7'h08, 64'hFF);
		send(trace_pack_pkg::FMT_CONTROL, trace_pack_pkg::CODE_DROP_B,
			7'h08, 64'hFF);
		send(trace_pack_pkg::FMT_OTHER, 4'h0, 7'h0D, 64'h1ABD);
		send(trace_pack_pkg::FMT_ADDRESS, 4'h0, 7'h0A, 64'h2A7);
		idle(2);
		trace_en = 1'b0;
		expect_word({39'h0, 9'h153, 12'hD5E, 4'h1});
		idle(3);
		trace_en = 1'b1;
		cyc_acc = 1'b1;
		$display("test inaccurate done");
	endtask
	task automatic test_backpressure;
		pin_width = trace_pack_pkg::PINW_4;
		saw_stall = 1'b0;
		idle(1);
		repeat (25) send(trace_pack_pkg::FMT_OTHER, 4'h0, 7'h0C, 64'h5A3);
		idle(1);
		repeat (5) expect_word({{5{12'h5A3}}, 4'h1});
		chk(64'(saw_stall), 64'h1);
		chk(64'(mem_cnt), 64'(nw));
		chk(64'(mem_err), 64'h0);
		$display("test backpressure done");
	endtask
	initial begin
		#200000;
		fails++;
		print_verdict();
	end
	initial begin
		fails = 0;
		checks = 0;
		nw = 0;
		rst_n = 1'b0;
		fmt_valid = 1'b0;
		fmt = '0;
		trace_en = 1'b1;
		cyc_acc = 1'b1;
		onchip_en = 1'b1;
		probe_en = 1'b1;
		pin_width = trace_pack_pkg::PINW_8;
		saw_stall = 1'b0;
		saw_clr = 1'b0;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		idle(2);
		test_reset();
		test_pack(trace_pack_pkg::PINW_4);
		test_pack(trace_pack_pkg::PINW_8);
		test_pack(trace_pack_pkg::PINW_16);
		test_spill_stop();
		test_inaccurate();
		test_backpressure();
		print_verdict();
	end
endmodule
